// *** pkg/plgc_pkg.sv ***
// Constants, field layout and state codes for the clock control block.
// Assumes one core clock; slow and main clocks arrive as one-cycle ticks.
//
// What this block does
// - Input divider ratio 1 to 255.
// - Zero ratio keeps divider and loop low.
// - Loop rate is source times (mult+1)/div.
// - Zero multiplier disables loop; nonzero re-enables.
// - Loop write clears lock, reloads lock counter.
// - Counter counts slow ticks; zero sets lock.
// - Source select field picks master source.
// - Master prescaler divides by 1 to 64.
// - Master divider derives master from processor clock.
// - Master register write clears ready until established.
// - Disable register stops processor; status readable.
// - Processor runs after reset; interrupts restart it.
// - Processor stops after current instruction completes.
// - USB clock enable, disable and status bits.
// - Peripheral clocks gated by enable/disable registers.
// - Peripheral disable immediate; all off after reset.
// - Peripheral bit index equals peripheral identifier.
// - Four outputs: select source, divide 1 to 64.
// - Output enable/disable bits, status and ready flag.
// - Master source resets to slow clock.
// - Master divider codes 0,1,2 give 1,2,4.
// - Unlocked loop falls back; ready stays low.
package plgc_pkg;
  // Register byte offsets
  localparam logic [7:0] SCER_OFS  = 8'h00;
  localparam logic [7:0] SCDR_OFS  = 8'h04;
  localparam logic [7:0] SCSR_OFS  = 8'h08;
  localparam logic [7:0] PCER_OFS  = 8'h10;
  localparam logic [7:0] PCDR_OFS  = 8'h14;
  localparam logic [7:0] PCSR_OFS  = 8'h18;
  localparam logic [7:0] LOOPA_OFS = 8'h28;
  localparam logic [7:0] LOOPB_OFS = 8'h2C;
  localparam logic [7:0] MCKR_OFS  = 8'h30;
  localparam logic [7:0] PCK0_OFS  = 8'h40;
  localparam logic [7:0] SR_OFS    = 8'h68;
  // Loop config fields
  localparam int LOOP_DIV_LSB = 0;
  localparam int LOOP_CNT_LSB = 8;
  localparam int LOOP_MUL_LSB = 16;
  localparam int LOOP_USB_LSB = 28;
  localparam logic [31:0] LOOP_FIELD_MASK = 32'h37FF_3FFF;
  // Master clock and programmable output fields
  localparam int CSS_LSB  = 0;
  localparam int PRESCALER_SELECT_LSB = 2;
  localparam int MASTER_DIVIDER_SELECT_LSB = 8;
  localparam logic [31:0] MCKR_FIELD_MASK = 32'h0000_031F;
  localparam logic [31:0] PCK_FIELD_MASK  = 32'h0000_001F;
  // Status bit positions
  localparam int SC_PROC_BIT = 0;
  localparam int SC_USB_BIT  = 7;
  localparam int SC_PROG_LSB = 8;
  localparam int SR_LOCK_FLAG_A    = 1;
  localparam int SR_LOCK_FLAG_B    = 2;
  localparam int SR_MRDY     = 3;
  localparam int SR_PROG_LSB = 8;
  // Reset values
  localparam logic [31:0] LOOP_RST = 32'h0000_0000;
  localparam logic [31:0] MCKR_RST = 32'h0000_0000;
  localparam logic [31:0] PCK_RST  = 32'h0000_0000;
  localparam logic [31:0] PCSR_RST = 32'h0000_0000;
  // Clock source codes
  localparam logic [1:0] CSS_SLOW  = 2'h0;
  localparam logic [1:0] CSS_MAIN  = 2'h1;
  localparam logic [1:0] CSS_LOOPA = 2'h2;
  localparam logic [1:0] CSS_LOOPB = 2'h3;
  // Rate accumulator ceiling
  localparam logic [15:0] PEND_LIMIT = 16'hF000;

  typedef enum logic [2:0] {
    PROC_RUN   = 3'b001,
    PROC_DRAIN = 3'b010,
    PROC_IDLE  = 3'b100
  } plgc_proc_t;
endpackage

// *** verilog/plgc_core.sv ***
// Clock synthesis loops, master clock selection and clock gating.
// Assumes slow and main clocks arrive as one-cycle ticks on core_clk,
// and that every generated clock leaves as a one-cycle tick.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module plgc_core (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        slowTick,
  input  wire logic        mainTick,
  input  wire logic        instrDone,
  input  wire logic        wakeIrq,
  output logic      [1:0]  loopTick,
  output logic             masterTick,
  output logic             procTick,
  output logic             usbTick,
  output logic      [31:0] periphClkEn,
  output logic      [3:0]  progClkOut
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic presHit(input logic [5:0] cnt,
                                   input logic [2:0] prescaler_select);
    presHit = (cnt == 6'((7'h01 << prescaler_select) - 7'h01));
  endfunction

  function automatic logic divHit(input logic [1:0] cnt,
                                  input logic [1:0] sel);
    divHit = (sel == 2'h0) || (sel == 2'h1 && cnt[0]) ||
             (sel == 2'h2 && cnt == 2'h3);
  endfunction

  function automatic logic srcTick(input logic [1:0] clock_source_select,
                                   input logic       slw,
                                   input logic       mn,
                                   input logic       la,
                                   input logic       lb);
    case (clock_source_select)
      plgc_pkg::CSS_SLOW:  srcTick = slw;
      plgc_pkg::CSS_MAIN:  srcTick = mn;
      plgc_pkg::CSS_LOOPA: srcTick = la;
      default:             srcTick = lb;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]          loopCfg_r  [2];
  logic [5:0]           lockCnt_r  [2];
  logic [1:0]           lockFlag_r;
  logic [1:0]           lockBusy_r;
  logic [15:0]          pend_r     [2];
  logic [1:0]           loopTick_r;
  logic [31:0]          mck_r;
  logic [5:0]           mckPres_r;
  logic [1:0]           mckDiv_r;
  logic                 mrdy_r;
  logic                 mrdyPend_r;
  plgc_pkg::plgc_proc_t procSt_r;
  logic                 usbRun_r;
  logic [1:0]           usbCnt_r;
  logic [31:0]          pcsr_r;
  logic [31:0]          pckCfg_r   [4];
  logic [5:0]           progCnt_r  [4];
  logic [3:0]           progRun_r;
  logic [3:0]           progRdy_r;
  logic [3:0]           progOut_r;
  logic                 procTick_r;
  logic                 masterTick_r;
  logic                 usbTick_r;
  logic [31:0]          regRdata_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       wrScer;
  logic       wrScdr;
  logic       wrPcer;
  logic       wrPcdr;
  logic       wrMck;
  logic [1:0] wrLoop;
  logic [3:0] wrPck;

  always_comb begin
    wrScer    = regWr && regAddr == plgc_pkg::SCER_OFS;
    wrScdr    = regWr && regAddr == plgc_pkg::SCDR_OFS;
    wrPcer    = regWr && regAddr == plgc_pkg::PCER_OFS;
    wrPcdr    = regWr && regAddr == plgc_pkg::PCDR_OFS;
    wrMck     = regWr && regAddr == plgc_pkg::MCKR_OFS;
    wrLoop[0] = regWr && regAddr == plgc_pkg::LOOPA_OFS;
    wrLoop[1] = regWr && regAddr == plgc_pkg::LOOPB_OFS;
    for (int k = 0; k < 4; k++) begin
      wrPck[k] = regWr && regAddr == plgc_pkg::PCK0_OFS + 8'(4 * k);
    end
  end

  // ----------------------------------------------------------------
  // Synthesis loops
  // ----------------------------------------------------------------
  logic [7:0]  loopDiv [2];
  logic [10:0] loopMul [2];
  logic [15:0] loopInc [2];
  logic [1:0]  loopOn;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      loopDiv[i] = loopCfg_r[i][plgc_pkg::LOOP_DIV_LSB +: 8];
      loopMul[i] = loopCfg_r[i][plgc_pkg::LOOP_MUL_LSB +: 11];
      loopOn[i]  = loopMul[i] != 11'h000 && loopDiv[i] != 8'h00;
      loopInc[i] = (mainTick && pend_r[i] < plgc_pkg::PEND_LIMIT) ?
                   16'(loopMul[i]) + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        loopCfg_r[i] <= plgc_pkg::LOOP_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrLoop[i]) begin
          loopCfg_r[i] <= regWdata & plgc_pkg::LOOP_FIELD_MASK;
        end
      end
    end
  end

  // Lock counters on slow ticks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lockFlag_r <= 2'h0;
      lockBusy_r <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        lockCnt_r[i] <= 6'h00;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrLoop[i]) begin
          lockFlag_r[i] <= 1'b0;
          lockBusy_r[i] <= 1'b1;
          lockCnt_r[i]  <= regWdata[plgc_pkg::LOOP_CNT_LSB +: 6];
        end else if (lockBusy_r[i] && loopMul[i] != 11'h000) begin
          if (lockCnt_r[i] == 6'h00) begin
            lockFlag_r[i] <= 1'b1;
            lockBusy_r[i] <= 1'b0;
          end else if (slowTick) begin
            lockCnt_r[i] <= lockCnt_r[i] - 6'h01;
          end
        end
      end
    end
  end

  // Rate accumulator: (mult+1) per main tick, one out per div
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loopTick_r <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        pend_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        loopTick_r[i] <= 1'b0;
        if (wrLoop[i] || !loopOn[i]) begin
          pend_r[i] <= 16'h0000;
        end else if (pend_r[i] >= 16'(loopDiv[i])) begin
          loopTick_r[i] <= 1'b1;
          pend_r[i]     <= pend_r[i] - 16'(loopDiv[i]) + loopInc[i];
        end else begin
          pend_r[i] <= pend_r[i] + loopInc[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock
  // ----------------------------------------------------------------
  logic [1:0] mckCss;
  logic [1:0] mckCssEff;
  logic [2:0] mckPres;
  logic [1:0] mckMdiv;
  logic       mckFallback;
  logic       mckSrc;
  logic       presTick;
  logic       masterRaw;

  always_comb begin
    mckCss      = mck_r[plgc_pkg::CSS_LSB +: 2];
    mckPres     = mck_r[plgc_pkg::PRESCALER_SELECT_LSB +: 3];
    mckMdiv     = mck_r[plgc_pkg::MASTER_DIVIDER_SELECT_LSB +: 2];
    mckCssEff   = mckCss;
    mckFallback = 1'b0;
    if (mckCss == plgc_pkg::CSS_LOOPA && !lockFlag_r[0]) begin
      mckCssEff   = plgc_pkg::CSS_SLOW;
      mckFallback = 1'b1;
    end else if (mckCss == plgc_pkg::CSS_LOOPB && !lockFlag_r[1]) begin
      mckCssEff   = plgc_pkg::CSS_MAIN;
      mckFallback = 1'b1;
    end
    mckSrc    = srcTick(mckCssEff, slowTick, mainTick,
                        loopTick_r[0], loopTick_r[1]);
    presTick  = mckSrc && presHit(mckPres_r, mckPres);
    masterRaw = presTick && divHit(mckDiv_r, mckMdiv);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mck_r <= plgc_pkg::MCKR_RST;
    end else if (wrMck) begin
      mck_r <= regWdata & plgc_pkg::MCKR_FIELD_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || wrMck) begin
      mckPres_r <= 6'h00;
      mckDiv_r  <= 2'h0;
    end else begin
      if (presTick) begin
        mckPres_r <= 6'h00;
        mckDiv_r  <= masterRaw ? 2'h0 : mckDiv_r + 2'h1;
      end else if (mckSrc) begin
        mckPres_r <= mckPres_r + 6'h01;
      end
    end
  end

  // Ready flag: restarted by each write, set on first new master edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mrdy_r     <= 1'b1;
      mrdyPend_r <= 1'b0;
    end else if (wrMck || mckFallback) begin
      mrdy_r     <= 1'b0;
      mrdyPend_r <= 1'b1;
    end else if (mrdyPend_r && masterRaw) begin
      mrdy_r     <= 1'b1;
      mrdyPend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Processor clock gating
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      procSt_r <= plgc_pkg::PROC_RUN;
    end else begin
      case (procSt_r)
        plgc_pkg::PROC_RUN: begin
          if (wrScdr && regWdata[plgc_pkg::SC_PROC_BIT] && !wakeIrq) begin
            procSt_r <= plgc_pkg::PROC_DRAIN;
          end
        end
        plgc_pkg::PROC_DRAIN: begin
          if (wakeIrq || (wrScer && regWdata[plgc_pkg::SC_PROC_BIT])) begin
            procSt_r <= plgc_pkg::PROC_RUN;
          end else if (instrDone) begin
            procSt_r <= plgc_pkg::PROC_IDLE;
          end
        end
        plgc_pkg::PROC_IDLE: begin
          if (wakeIrq || (wrScer && regWdata[plgc_pkg::SC_PROC_BIT])) begin
            procSt_r <= plgc_pkg::PROC_RUN;
          end
        end
        default: procSt_r <= plgc_pkg::PROC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // USB and peripheral gating
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      usbRun_r <= 1'b0;
    end else if (wrScer && regWdata[plgc_pkg::SC_USB_BIT]) begin
      usbRun_r <= 1'b1;
    end else if (wrScdr && regWdata[plgc_pkg::SC_USB_BIT]) begin
      usbRun_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      usbCnt_r <= 2'h0;
    end else if (loopTick_r[1]) begin
      usbCnt_r <= divHit(usbCnt_r,
                  loopCfg_r[1][plgc_pkg::LOOP_USB_LSB +: 2]) ?
                  2'h0 : usbCnt_r + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pcsr_r <= plgc_pkg::PCSR_RST;
    end else if (wrPcer) begin
      pcsr_r <= pcsr_r | regWdata;
    end else if (wrPcdr) begin
      pcsr_r <= pcsr_r & ~regWdata;
    end
  end

  // ----------------------------------------------------------------
  // Programmable outputs
  // ----------------------------------------------------------------
  logic [3:0] progSrc;
  logic [3:0] progHit;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      progSrc[k] = srcTick(pckCfg_r[k][plgc_pkg::CSS_LSB +: 2],
                           slowTick, mainTick,
                           loopTick_r[0], loopTick_r[1]);
      progHit[k] = progSrc[k] &&
                   presHit(progCnt_r[k],
                           pckCfg_r[k][plgc_pkg::PRESCALER_SELECT_LSB +: 3]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      progRun_r <= 4'h0;
    end else if (wrScer) begin
      progRun_r <= progRun_r |
                   regWdata[plgc_pkg::SC_PROG_LSB +: 4];
    end else if (wrScdr) begin
      progRun_r <= progRun_r &
                   ~regWdata[plgc_pkg::SC_PROG_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      progRdy_r <= 4'h0;
      progOut_r <= 4'h0;
      for (int k = 0; k < 4; k++) begin
        pckCfg_r[k]  <= plgc_pkg::PCK_RST;
        progCnt_r[k] <= 6'h00;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        progOut_r[k] <= progHit[k] && progRun_r[k];
        if (wrPck[k]) begin
          pckCfg_r[k]  <= regWdata & plgc_pkg::PCK_FIELD_MASK;
          progCnt_r[k] <= 6'h00;
          progRdy_r[k] <= 1'b0;
        end else if (progHit[k]) begin
          progCnt_r[k] <= 6'h00;
          progRdy_r[k] <= 1'b1;
        end else if (progSrc[k]) begin
          progCnt_r[k] <= progCnt_r[k] + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output ticks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      procTick_r   <= 1'b0;
      masterTick_r <= 1'b0;
      usbTick_r    <= 1'b0;
    end else begin
      procTick_r   <= presTick && procSt_r != plgc_pkg::PROC_IDLE;
      masterTick_r <= masterRaw;
      usbTick_r    <= loopTick_r[1] && usbRun_r &&
                      divHit(usbCnt_r,
                      loopCfg_r[1][plgc_pkg::LOOP_USB_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] scsrVal;
  logic [31:0] srVal;

  always_comb begin
    scsrVal = 32'h0000_0000;
    scsrVal[plgc_pkg::SC_PROC_BIT] = procSt_r != plgc_pkg::PROC_IDLE;
    scsrVal[plgc_pkg::SC_USB_BIT]  = usbRun_r;
    scsrVal[plgc_pkg::SC_PROG_LSB +: 4] = progRun_r;
    srVal = 32'h0000_0000;
    srVal[plgc_pkg::SR_LOCK_FLAG_A] = lockFlag_r[0];
    srVal[plgc_pkg::SR_LOCK_FLAG_B] = lockFlag_r[1];
    srVal[plgc_pkg::SR_MRDY]  = mrdy_r;
    srVal[plgc_pkg::SR_PROG_LSB +: 4] = progRdy_r;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdata_r <= 32'h0000_0000;
    end else begin
      regRdata_r <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          plgc_pkg::SCSR_OFS:         regRdata_r <= scsrVal;
          plgc_pkg::PCSR_OFS:         regRdata_r <= pcsr_r;
          plgc_pkg::LOOPA_OFS:        regRdata_r <= loopCfg_r[0];
          plgc_pkg::LOOPB_OFS:        regRdata_r <= loopCfg_r[1];
          plgc_pkg::MCKR_OFS:         regRdata_r <= mck_r;
          plgc_pkg::PCK0_OFS:         regRdata_r <= pckCfg_r[0];
          plgc_pkg::PCK0_OFS + 8'h04: regRdata_r <= pckCfg_r[1];
          plgc_pkg::PCK0_OFS + 8'h08: regRdata_r <= pckCfg_r[2];
          plgc_pkg::PCK0_OFS + 8'h0C: regRdata_r <= pckCfg_r[3];
          plgc_pkg::SR_OFS:           regRdata_r <= srVal;
          default:                    regRdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign regRdata    = regRdata_r;
  assign loopTick    = loopTick_r;
  assign masterTick  = masterTick_r;
  assign procTick    = procTick_r;
  assign usbTick     = usbTick_r;
  assign periphClkEn = pcsr_r;
  assign progClkOut  = progOut_r;

endmodule // plgc_core

// *** testbench/plgc_core_properties.sv ***
// Port assertions for the clock control block.
// Bound to plgc_core; watches only its ports.
`timescale 1ns/1ps
module plgc_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  input wire logic [1:0]  loopTick,
  input wire logic [31:0] periphClkEn
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic divZero_r;
  wire  pcWr = regWr && regAddr == plgc_pkg::PCER_OFS;
  wire  pdWr = regWr && regAddr == plgc_pkg::PCDR_OFS;
  wire  srRd = regRd && regAddr == plgc_pkg::SR_OFS;
  // -------------------------------
  // Divider A zero tracking
  // -------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      divZero_r <= 1'b1;
    else if (regWr && regAddr == plgc_pkg::LOOPA_OFS)
      divZero_r <= regWdata[7:0] == 8'h00;
  end
  rd_idle_a: assert property (
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  pc_en_a: assert property (
    pcWr |=> (periphClkEn & $past(regWdata)) == $past(regWdata))
    else $error("peripheral enable lost");
  pc_off_a: assert property (
    pdWr |=> (periphClkEn & $past(regWdata)) == 32'h0000_0000)
    else $error("peripheral disable not immediate");
  pc_hold_a: assert property (
    !pcWr && !pdWr |=> $stable(periphClkEn))
    else $error("peripheral clocks changed without write");
  pc_rst_a: assert property (
    $fell(sys_rst) |-> periphClkEn == 32'h0000_0000)
    else $error("peripheral clocks on after reset");
  pc_stat_a: assert property (
    regRd && regAddr == plgc_pkg::PCSR_OFS |=>
      regRdata == $past(periphClkEn))
    else $error("peripheral status differs from enables");
  lock_clr_a: assert property (
    regWr && regAddr == plgc_pkg::LOOPA_OFS ##1 srRd |=>
      !regRdata[plgc_pkg::SR_LOCK_FLAG_A])
    else $error("lock flag not cleared by loop write");
  rdy_clr_a: assert property (
    regWr && regAddr == plgc_pkg::MCKR_OFS ##1 srRd |=>
      !regRdata[plgc_pkg::SR_MRDY])
    else $error("ready flag not cleared by master write");
  div_zero_a: assert property (
    divZero_r && $past(divZero_r) && $past(divZero_r, 2) |->
      !loopTick[0])
    else $error("loop ticks with zero divider");
  cover property (pcWr ##1 pdWr);
  cover property (regWr && regAddr == plgc_pkg::MCKR_OFS ##1 srRd);
  cover property (loopTick[0] ##[1:8] loopTick[0]);
endmodule // plgc_props

bind plgc_core plgc_props i_plgc_props (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .loopTick(loopTick),
  .periphClkEn(periphClkEn)
);

// *** testbench/tb_top.sv ***
// Self-checking bench for plgc_core.
// Slow and main clocks are bench-made one-cycle ticks.
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        slowTick = 1'b0;
  logic        mainTick = 1'b0;
  logic        instrDone = 1'b0;
  logic        wakeIrq  = 1'b0;
  logic [31:0] regRdata, periphClkEn, v, w, rdMask;
  logic [1:0]  loopTick;
  logic [3:0]  progClkOut, drv;
  logic        masterTick, procTick, usbTick, rdPend;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cnt [5];
  logic [31:0] expQ [$];
  logic [31:0] mskQ [$];
  logic [31:0] lc [3] = '{32'h0001_0301, 32'h00FE_00FF, 32'h0001_0000};
  int          le [3] = '{32, 16, 0};
  always #50 core_clk = ~core_clk;
  plgc_core i_plgc_core (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .slowTick(slowTick), .mainTick(mainTick),
    .instrDone(instrDone), .wakeIrq(wakeIrq), .loopTick(loopTick),
    .masterTick(masterTick), .procTick(procTick), .usbTick(usbTick),
    .periphClkEn(periphClkEn), .progClkOut(progClkOut));
  // -------------------------------
  // Drivers and checks
  // -------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic c, r, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    cnt[0] += loopTick[0];
    cnt[1] += masterTick;
    cnt[2] += procTick;
    cnt[3] += usbTick;
    cnt[4] += $countones(progClkOut);
    {regWr, regRd, regAddr, regWdata} <= {c, r, a, d};
    {slowTick, mainTick, instrDone, wakeIrq} <= drv;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = ALL);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
  endtask
  task automatic pulse(input int b);
    drv[b] = 1'b1;
    idle(1);
    drv[b] = 1'b0;
  endtask
  task automatic run(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      pulse(2);
      idle(3);
    end
    idle(4);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) rdPend <= regRd;
  always @(negedge core_clk) begin
    if (rdPend === 1'b1) begin
      rdMask = mskQ.pop_front();
      chk("rdata", expQ.pop_front(), regRdata & rdMask);
    end
  end
  initial begin
    #2_000_000;
    miscompares++;
    finish_test;
  end
  // -------------------------------
  // Scenarios
  // -------------------------------
  initial begin
    void'($urandom(32'h696f));
    drv = 4'h0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h08, 32'h0000_0001, 32'h0000_0F81);
    rd(8'h18, 32'h0000_0000);
    rd(8'h28, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    rd(8'h68, 32'h0000_0008, 32'h0000_000E);
    rd(8'h7C, 32'h0000_0000);
    v = $urandom();
    wr(8'h10, v);
    wr(8'h14, 32'h0000_0000);
    rd(8'h18, v);
    w = $urandom();
    wr(8'h14, w);
    rd(8'h18, v & ~w);
    idle(1);
    chk("periph", v & ~w, periphClkEn);
    for (int i = 0; i < 32; i += 5) begin
      wr(8'h14, ALL);
      wr(8'h10, 32'h0000_0001 << i);
      rd(8'h18, 32'h0000_0001 << i);
    end
    wr(8'h28, 32'h0001_0301);
    rd(8'h68, 32'h0000_0000, 32'h0000_0002);
    rd(8'h28, 32'h0001_0301);
    repeat (2) pulse(3);
    idle(2);
    rd(8'h68, 32'h0000_0000, 32'h0000_0002);
    pulse(3);
    idle(3);
    rd(8'h68, 32'h0000_0002, 32'h0000_0002);
    foreach (lc[i]) begin
      wr(8'h28, lc[i]);
      run(16);
      chk("loopA", 1'b1, cnt[0] inside {[le[i] - 1:le[i] + 1]});
    end
    wr(8'h2C, 32'h0000_0001);
    repeat (2) pulse(3);
    idle(2);
    rd(8'h68, 32'h0000_0000, 32'h0000_0004);
    wr(8'h2C, 32'h0001_0001);
    idle(3);
    rd(8'h68, 32'h0000_0004, 32'h0000_0004);
    wr(8'h30, 32'h0000_0101);
    rd(8'h68, 32'h0000_0000, 32'h0000_0008);
    rd(8'h30, 32'h0000_0101);
    run(16);
    chk("proc", 32'd16, cnt[2]);
    chk("master", 32'd8, cnt[1]);
    rd(8'h68, 32'h0000_0008, 32'h0000_0008);
    wr(8'h30, 32'h0000_0009);
    run(16);
    chk("master", 32'd4, cnt[1]);
    wr(8'h28, 32'h0001_3F01);
    wr(8'h30, 32'h0000_0002);
    run(8);
    chk("master", 32'd0, cnt[1]);
    rd(8'h68, 32'h0000_0000, 32'h0000_0008);
    wr(8'h30, 32'h0000_0001);
    wr(8'h04, 32'h0000_0001);
    idle(4);
    rd(8'h08, 32'h0000_0001, 32'h0000_0001);
    pulse(1);
    idle(2);
    rd(8'h08, 32'h0000_0000, 32'h0000_0001);
    run(8);
    chk("proc", 32'd0, cnt[2]);
    chk("master", 32'd8, cnt[1]);
    pulse(0);
    idle(2);
    rd(8'h08, 32'h0000_0001, 32'h0000_0001);
    wr(8'h00, 32'h0000_0080);
    rd(8'h08, 32'h0000_0080, 32'h0000_0080);
    run(8);
    chk("proc", 32'd8, cnt[2]);
    chk("usb", 1'b1, cnt[3] > 0);
    wr(8'h04, 32'h0000_0080);
    rd(8'h08, 32'h0000_0000, 32'h0000_0080);
    run(8);
    chk("usb", 32'd0, cnt[3]);
    for (int i = 0; i < 4; i++) begin
      wr(8'h40 + 8'(i * 4), 32'(i << 2) | 32'h0000_0001);
      wr(8'h00, 32'h0000_0100 << i);
      run(32);
      chk("prog", 32'(32 >> i), cnt[4]);
      rd(8'h68, 32'h0000_0100 << i, 32'h0000_0100 << i);
      wr(8'h04, 32'h0000_0100 << i);
    end
    idle(4);
    finish_test;
  end
endmodule // tb_top
